// file: rtl/hpc_pkg.sv
// Purpose: Shared constants and types for the hibernate power controller
// Assumes: One clock at 100 MHz; reference tick derived by enable pulses
// Notes: Control bits arrive as plain ports grouped in a packed struct
package hpc_pkg;

  localparam int unsigned HPC_CNT_W = 32;
  localparam int unsigned HPC_MEM_WORDS = 64;
  localparam int unsigned HPC_MEM_AW = 6;
  localparam int unsigned HPC_XTAL_DIV = 128;
  localparam int unsigned HPC_TRIM_PERIOD = 64;
  localparam logic [15:0] HPC_TRIM_RESET = 16'h7fff;
  localparam logic [15:0] HPC_PREDIV_NOMINAL = 16'h7fff;
  localparam logic [31:0] HPC_COUNTER_RESET = 32'h0000_0000;
  localparam logic [31:0] HPC_MATCH_RESET = 32'hffff_ffff;

  typedef enum logic [1:0] {
    HPC_ST_RUN = 2'b00,
    HPC_ST_ENTER = 2'b01,
    HPC_ST_SLEEP = 2'b10
  } hpc_state_type;

  typedef struct packed {
    logic osc_enable;
    logic osc_select;
    logic counter_en;
    logic sleep_request;
    logic pin_resume_en;
    logic match_resume_en;
    logic supply_monitor_en;
    logic low_supply_abort;
  } hpc_ctrl_type;

  typedef struct packed {
    logic match0;
    logic match1;
    logic resume;
    logic supply_low;
  } hpc_events_type;

endpackage

// file: rtl/hpc_ref_tick.sv
// Purpose: Derives the 32.768 kHz reference tick from the oscillator input
// Assumes: osc_edge_i is a one-cycle pulse per rising edge of the reference input
// Notes: Crystal mode divides by the crystal divide ratio
`timescale 1ns/1ps
module hpc_ref_tick
  import hpc_pkg::*;
#(
  parameter int unsigned DIV = HPC_XTAL_DIV
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic osc_enable_i,
  input wire logic osc_select_i,
  input wire logic osc_edge_i,
  // Tick out
  output logic tick_o
);

  localparam int unsigned DW = $clog2(DIV);

  initial
  begin
    if (DIV < 2) $error("hpc_ref_tick: DIV must be at least 2");
  end

  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic tick_next;
  logic tick_reg;

  always_comb
  begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (!osc_enable_i)
    begin
      div_next = '0;
    end
    else if (osc_edge_i)
    begin
      if (osc_select_i)
      begin
        tick_next = 1'b1;
      end
      else if (div_reg == DW'(DIV - 1))
      begin
        div_next = '0;
        tick_next = 1'b1;
      end
      else
      begin
        div_next = div_reg + DW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// file: rtl/hpc_top.sv
// Purpose: Hibernate power controller with seconds counter, matches and retained memory
// Assumes: All inputs synchronous to clk_i except resume_n_i and resetn_i
// Notes: Reference clock arrives as an ordinary sampled input
`timescale 1ns/1ps
module hpc_top
  import hpc_pkg::*;
#(
  parameter int unsigned CNT_W = HPC_CNT_W,
  parameter int unsigned MEM_WORDS = HPC_MEM_WORDS
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Reference oscillator and supply sense
  input wire logic osc_in_i,
  input wire logic supply_low_i,
  // External resume, active low, asynchronous
  input wire logic resume_n_i,
  // Control
  input wire hpc_ctrl_type ctrl_i,
  input wire logic [15:0] predivider_trim_i,
  // Counter load and match values
  input wire logic counter_load_i,
  input wire logic [31:0] counter_load_value_i,
  input wire logic [31:0] match0_i,
  input wire logic [31:0] match1_i,
  // Interrupt mask and clear
  input wire hpc_events_type irq_mask_i,
  input wire hpc_events_type irq_clear_i,
  // Retained memory port
  input wire logic mem_write_i,
  input wire logic [HPC_MEM_AW-1:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o,
  // Status
  output logic power_off_n_o,
  output logic [31:0] counter_o,
  output hpc_events_type raw_status_o,
  output hpc_events_type masked_status_o,
  output logic supply_low_flag_o,
  output logic irq_o,
  output logic sleeping_o
);

  initial
  begin
    if (CNT_W != 32) $error("hpc_top: CNT_W must be 32");
    if (MEM_WORDS != 64) $error("hpc_top: MEM_WORDS must be 64");
  end

  // Reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Resume synchroniser and oscillator edge detect
  logic rsm_s1_reg;
  logic rsm_s2_reg;
  logic rsm_s3_reg;
  logic osc_d_reg;
  logic resume_rise;
  logic osc_edge;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsm_s1_reg <= 1'b0;
      rsm_s2_reg <= 1'b0;
      rsm_s3_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end
    else
    begin
      rsm_s1_reg <= ~resume_n_i;
      rsm_s2_reg <= rsm_s1_reg;
      rsm_s3_reg <= rsm_s2_reg;
      osc_d_reg <= osc_in_i;
    end
  end
  assign resume_rise = rsm_s2_reg & ~rsm_s3_reg;
  assign osc_edge = osc_in_i & ~osc_d_reg;

  // Reference tick
  logic ref_tick;
  hpc_ref_tick #(
    .DIV(HPC_XTAL_DIV)
  ) u_ref_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .osc_enable_i(ctrl_i.osc_enable),
    .osc_select_i(ctrl_i.osc_select),
    .osc_edge_i(osc_edge),
    .tick_o(ref_tick)
  );

  // Predivider and seconds counter
  logic [15:0] prediv_reg;
  logic [15:0] prediv_next;
  logic [5:0] sec_mod_reg;
  logic [5:0] sec_mod_next;
  logic [31:0] counter_reg;
  logic [31:0] counter_next;
  logic sec_tick;
  always_comb
  begin
    prediv_next = prediv_reg;
    sec_mod_next = sec_mod_reg;
    counter_next = counter_reg;
    sec_tick = 1'b0;
    if (counter_load_i)
    begin
      counter_next = counter_load_value_i;
      prediv_next = '0;
    end
    else if (ctrl_i.counter_en && ref_tick)
    begin
      if ((sec_mod_reg == 6'h00 && prediv_reg >= predivider_trim_i) ||
          (sec_mod_reg != 6'h00 && prediv_reg >= HPC_PREDIV_NOMINAL))
      begin
        prediv_next = '0;
        sec_mod_next = sec_mod_reg + 6'h01;
        counter_next = counter_reg + 32'h0000_0001;
        sec_tick = 1'b1;
      end
      else
      begin
        prediv_next = prediv_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prediv_reg <= 16'h0000;
      sec_mod_reg <= 6'h00;
      counter_reg <= HPC_COUNTER_RESET;
    end
    else
    begin
      prediv_reg <= prediv_next;
      sec_mod_reg <= sec_mod_next;
      counter_reg <= counter_next;
    end
  end

  // Match compare, qualified by a second boundary so each match fires once
  logic hit0;
  logic hit1;
  assign hit0 = sec_tick && (counter_next == match0_i);
  assign hit1 = sec_tick && (counter_next == match1_i);

  // Power state
  hpc_state_type state_reg;
  hpc_state_type state_next;
  logic pwr_n_reg;
  logic pwr_n_next;
  logic wake;
  logic blocked;
  assign blocked = ctrl_i.supply_monitor_en & ctrl_i.low_supply_abort & supply_low_i;
  assign wake = (ctrl_i.pin_resume_en & resume_rise) |
                (ctrl_i.match_resume_en & (hit0 | hit1));

  always_comb
  begin
    state_next = state_reg;
    pwr_n_next = pwr_n_reg;
    unique case (state_reg)
      HPC_ST_RUN:
      begin
        pwr_n_next = 1'b1;
        if (ctrl_i.sleep_request && !blocked &&
            (ctrl_i.pin_resume_en || ctrl_i.match_resume_en))
          state_next = HPC_ST_ENTER;
      end
      HPC_ST_ENTER:
      begin
        pwr_n_next = 1'b0;
        state_next = HPC_ST_SLEEP;
      end
      HPC_ST_SLEEP:
      begin
        if (wake)
        begin
          pwr_n_next = 1'b1;
          state_next = HPC_ST_RUN;
        end
      end
      default:
      begin
        pwr_n_next = 1'b1;
        state_next = HPC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= HPC_ST_RUN;
      pwr_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      pwr_n_reg <= pwr_n_next;
    end
  end

  // Sticky event flags; a set wins over a clear in the same cycle
  hpc_events_type raw_reg;
  hpc_events_type raw_next;
  hpc_events_type ev_set;
  always_comb
  begin
    ev_set.match0 = hit0;
    ev_set.match1 = hit1;
    ev_set.resume = resume_rise;
    ev_set.supply_low = ctrl_i.supply_monitor_en & supply_low_i &
                        (state_reg != HPC_ST_SLEEP);
    raw_next = (raw_reg & ~irq_clear_i) | ev_set;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      raw_reg <= '0;
    else
      raw_reg <= raw_next;
  end

  // Retained memory, not cleared by reset
  logic [31:0] mem_arr [MEM_WORDS];
  logic [31:0] rdata_reg;
  always_ff @(posedge clk_i)
  begin
    if (mem_write_i)
      mem_arr[mem_addr_i] <= mem_wdata_i;
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= mem_arr[mem_addr_i];
  end

  // Outputs
  assign mem_rdata_o = rdata_reg;
  assign power_off_n_o = pwr_n_reg;
  assign counter_o = counter_reg;
  assign raw_status_o = raw_reg;
  assign masked_status_o = raw_reg & irq_mask_i;
  assign supply_low_flag_o = raw_reg.supply_low;
  assign irq_o = |(raw_reg & irq_mask_i);
  assign sleeping_o = (state_reg == HPC_ST_SLEEP);

endmodule

// file: dv/hpc_partner.sv
// Purpose: Regulator and wake source beside the power controller
// Assumes: Wake pin idles high through its pull-up
// Notes: A press pulls the pin low for four cycles after a delay
`timescale 1ns/1ps
module hpc_partner (
  // Clock and bench commands
  input wire logic clk_i,
  input wire logic press_i,
  input wire logic [3:0] delay_i,
  // Device side
  input wire logic power_off_n_i,
  output logic resume_n_o,
  output logic vdd_on_o
);
  int cnt = 0;
  always @(posedge clk_i)
  begin
    cnt <= press_i ? int'(delay_i) + 4 : (cnt > 0 ? cnt - 1 : 0);
    vdd_on_o <= power_off_n_i;
  end
  assign #3 resume_n_o = !(cnt inside {[1:4]});
endmodule

// file: dv/hpc_top_asserts.sv
// Purpose: Port checks on the power controller
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached by bind
`timescale 1ns/1ps
module hpc_top_checker
  import hpc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_low_i,
  input wire logic resume_n_i,
  input wire hpc_ctrl_type ctrl_i,
  input wire logic counter_load_i,
  input wire logic [31:0] counter_load_value_i,
  input wire hpc_events_type irq_mask_i,
  // Outputs
  input wire logic power_off_n_o,
  input wire logic [31:0] counter_o,
  input wire hpc_events_type raw_status_o,
  input wire logic irq_o,
  input wire logic sleeping_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic may_sleep;
  assign may_sleep = ctrl_i.sleep_request && (ctrl_i.pin_resume_en || ctrl_i.match_resume_en)
    && !(ctrl_i.supply_monitor_en && ctrl_i.low_supply_abort && supply_low_i);
  sequence sleep_taken;
    power_off_n_o && may_sleep;
  endsequence
  sequence pin_press;
    sleeping_o && ctrl_i.pin_resume_en && $fell(resume_n_i) ##1 !resume_n_i [*3];
  endsequence
  power_pair_a: assert property (sleeping_o == !power_off_n_o)
    else $error("sleep flag and power enable disagree");
  enter_cause_a: assert property ($fell(power_off_n_o)
    |-> $past(may_sleep, 2) || $past(may_sleep, 3)) else $error("power cut without request");
  enter_timing_a: assert property (sleep_taken |-> ##[2:3] !power_off_n_o)
    else $error("accepted sleep did not cut power");
  wake_cause_a: assert property ($rose(power_off_n_o)
    |-> $past(ctrl_i.pin_resume_en || ctrl_i.match_resume_en)) else $error("wake not enabled");
  pin_wake_a: assert property (pin_press |-> ##[0:3] power_off_n_o)
    else $error("resume pin did not restore power");
  count_step_a: assert property ($changed(counter_o) && !$past(counter_load_i)
    |-> counter_o == $past(counter_o) + 32'h1) else $error("counter step not one");
  load_value_a: assert property (counter_load_i |=> counter_o == $past(counter_load_value_i))
    else $error("counter load value lost");
  supply_flag_a: assert property (ctrl_i.supply_monitor_en && supply_low_i && !sleeping_o
    |=> raw_status_o.supply_low) else $error("low supply flag not set");
  irq_out_a: assert property (irq_o == |(raw_status_o & irq_mask_i))
    else $error("interrupt output wrong");
endmodule
bind hpc_top hpc_top_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .supply_low_i(supply_low_i), .resume_n_i(resume_n_i), .ctrl_i(ctrl_i),
  .counter_load_i(counter_load_i), .counter_load_value_i(counter_load_value_i),
  .irq_mask_i(irq_mask_i), .power_off_n_o(power_off_n_o), .counter_o(counter_o),
  .raw_status_o(raw_status_o), .irq_o(irq_o), .sleeping_o(sleeping_o));

// file: dv/test_hibernate_power_controller.sv
// Purpose: Self-checking bench for the power controller
// Assumes: Inputs change on the falling clock edge
// Notes: Counter and memory modelled with integers and a queue
`timescale 1ns/1ps
module test_hibernate_power_controller
  import hpc_pkg::*;
;
  logic clk_i = 0, resetn_i = 0, osc = 0, low = 0, ld = 0, we = 0, press = 0;
  logic rn, vdd, pwr, irq, slp, flg;
  logic [3:0] dly = '0;
  logic [5:0] addr = '0;
  logic [15:0] trim = 16'h7fff;
  logic [31:0] lv = '0, wd = '0, rd, cnt, seed = 32'h0000_0060;
  logic [31:0] m0 = 32'h0000_0001, m1 = 32'h0000_0002;
  hpc_ctrl_type ctrl = '0;
  hpc_events_type mask = 4'h8, clr = '0, raw, msk;
  int miscompares = 0, checks_done = 0, exp_cnt = 0, mem_m [64];
  logic [5:0] aq [$];
  hpc_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .osc_in_i(osc), .supply_low_i(low),
    .resume_n_i(rn), .ctrl_i(ctrl), .predivider_trim_i(trim), .counter_load_i(ld),
    .counter_load_value_i(lv), .match0_i(m0), .match1_i(m1), .irq_mask_i(mask),
    .irq_clear_i(clr), .mem_write_i(we), .mem_addr_i(addr), .mem_wdata_i(wd),
    .mem_rdata_o(rd), .power_off_n_o(pwr), .counter_o(cnt), .raw_status_o(raw),
    .masked_status_o(msk), .supply_low_flag_o(flg), .irq_o(irq), .sleeping_o(slp));
  hpc_partner peer (.clk_i(clk_i), .press_i(press), .delay_i(dly), .power_off_n_i(pwr),
    .resume_n_o(rn), .vdd_on_o(vdd));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rst();
    resetn_i = 1'b0;
    exp_cnt = 0;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic osc_edges(input int n);
    repeat (n)
    begin
      osc = 1'b1;
      @(negedge clk_i);
      osc = 1'b0;
      repeat (2) @(negedge clk_i);
    end
    repeat (8) @(negedge clk_i);
  endtask
  task automatic wait_pwr(input logic v);
    for (int i = 0; i < 60 && pwr !== v; i++)
      @(negedge clk_i);
    @(negedge clk_i);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial
  begin
    ctrl.osc_enable = 1'b1;
    ctrl.counter_en = 1'b1;
    ctrl.match_resume_en = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      ctrl.osc_select = k < 2;
      trim = 16'(3 + 3 * (k % 2) - k / 2);
      m0 = k == 1 ? 32'h0000_0002 : 32'h0000_0001;
      m1 = k == 1 ? 32'h0000_0001 : 32'h0000_0002;
      rst();
      chk("reset state", {pwr, slp, irq, raw}, 7'h40);
      chk("reset count", cnt, HPC_COUNTER_RESET);
      ctrl.sleep_request = 1'b1;
      wait_pwr(1'b0);
      ctrl.sleep_request = 1'b0;
      chk("asleep", {pwr, slp, vdd}, 3'b010);
      osc_edges((int'(trim) + 1) * (k < 2 ? 1 : HPC_XTAL_DIV) - 1);
      chk("count", cnt, exp_cnt);
      osc_edges(1);
      exp_cnt++;
      chk("count", cnt, exp_cnt);
      chk("match wake", {raw, irq, pwr}, k == 1 ? 6'h11 : 6'h23);
    end
    repeat (3)
    begin
      seed = xs(seed);
      lv = seed;
      ld = 1'b1;
      @(negedge clk_i);
      ld = 1'b0;
      @(negedge clk_i);
      exp_cnt = lv;
      chk("load", cnt, exp_cnt);
    end
    clr = 4'hf;
    @(negedge clk_i);
    clr = 4'h0;
    chk("clear", {raw, irq}, 5'h00);
    we = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      addr = k == 0 ? 6'h00 : k == 1 ? 6'h3f : seed[5:0];
      wd = xs(seed);
      mem_m[addr] = wd;
      aq.push_back(addr);
      @(negedge clk_i);
    end
    we = 1'b0;
    ctrl.match_resume_en = 1'b0;
    ctrl.sleep_request = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("no wake source", pwr, 1'b1);
    ctrl.pin_resume_en = 1'b1;
    ctrl.supply_monitor_en = 1'b1;
    ctrl.low_supply_abort = 1'b1;
    low = 1'b1;
    mask = 4'h1;
    repeat (6) @(negedge clk_i);
    chk("abort", {pwr, flg, irq}, 3'b111);
    chk("masked", msk, 4'h1);
    low = 1'b0;
    wait_pwr(1'b0);
    ctrl.sleep_request = 1'b0;
    chk("asleep", pwr, 1'b0);
    dly = seed[3:0];
    press = 1'b1;
    @(negedge clk_i);
    press = 1'b0;
    wait_pwr(1'b1);
    chk("pin wake", {pwr, raw.resume}, 2'b11);
    foreach (aq[k])
    begin
      addr = aq[k];
      @(negedge clk_i);
      chk("memory", rd, mem_m[aq[k]]);
    end
    complete_run();
  end
endmodule
